// [shared/uda_pkg.sv]
// Constants and types for the user-defined cyclic I/O assembly block.
// Assumes a 32-bit APB register bus with byte addresses and 16-bit parameter words.
package uda_pkg;
    // ****************************************************************
    // Assembly formats
    // ****************************************************************
    localparam int FMT_W = 8;
    localparam logic [FMT_W-1:0] FMT_OUT_SERIAL = 8'h6a; // Output format 106
    localparam logic [FMT_W-1:0] FMT_IN_LINK = 8'h67;    // Input format 103
    localparam logic [FMT_W-1:0] FMT_IN_SERIAL = 8'h6b;  // Input format 107
    localparam logic [FMT_W-1:0] FMT_RESET = 8'h00;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int SLOTS = 4;
    localparam int NUM_SEL = 12;
    localparam int SEL_LINK_MON = 0;
    localparam int SEL_SER_WR = 4;
    localparam int SEL_SER_MON = 8;
    localparam int SEL_WIDTH = 16;
    localparam int WORD_W = 16;
    localparam int ASM_BYTES = 8;
    localparam int CNT_W = 8;
    localparam logic [SEL_WIDTH-1:0] SEL_UNASSIGNED = 16'h0000;
    localparam logic [SEL_WIDTH-1:0] SEL_RESET = 16'h0000;
    localparam logic [2:0] LAST_BYTE = 3'h7;
    localparam logic [1:0] LAST_SLOT = 2'h3;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam int ADDR_WIDTH = 12;
    localparam logic [11:0] OFS_OUT_FMT = 12'h000;
    localparam logic [11:0] OFS_IN_FMT = 12'h004;
    localparam logic [11:0] OFS_SEL_BASE = 12'h010;
    localparam logic [11:0] OFS_SEL_LAST = 12'h03c;
    localparam logic [11:0] OFS_STATUS = 12'h040;
    localparam int ST_APPLIED_LSB = 0;
    localparam int ST_DROPPED_LSB = 8;
    localparam int ST_RX_BUSY = 16;
    localparam int ST_TX_BUSY = 17;

    // ****************************************************************
    // State machines
    // ****************************************************************
    typedef enum logic [0:0] {RX_COLLECT, RX_WRITE} uda_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_READ, TX_LO, TX_HI} uda_tx_state_t;
endpackage

// [shared/uda_stream_if.sv]
// Valid/ready stream carrier between the assembly engine and its output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface uda_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [hw/uda_buf.sv]
// Small FIFO that decouples the input assembly from a stalling receiver.
// Assumes DEPTH is a power of two; read data come from registers.
`timescale 1ns/1ps
`default_nettype none
module uda_buf #(
    parameter int W = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Streams
    uda_stream_if.snk push,
    uda_stream_if.src pop
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] next_mem [DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [PW:0] fill, next_fill;
    logic do_push, do_pop;

    // Honest full and empty from the fill level
    assign push.ready = (fill != (PW+1)'(DEPTH));
    assign pop.valid = (fill != '0);
    assign pop.data = mem[rd_ptr];
    assign do_push = push.valid & push.ready;
    assign do_pop = pop.valid & pop.ready;

    // Next pointers, level and storage
    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_fill = fill;
        if (do_push) begin
            next_mem[wr_ptr] = push.data;
            next_wr_ptr = wr_ptr + 1'b1;
        end
        if (do_pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
        if (do_push && !do_pop) begin
            next_fill = fill + 1'b1;
        end else if (do_pop && !do_push) begin
            next_fill = fill - 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill <= next_fill;
        end
    end
endmodule // uda_buf
`default_nettype wire

// [hw/uda_assembly.sv]
// User-defined cyclic I/O assembly engine with its APB register file.
// Assumes the parameter store answers a monitor read in the same cycle
// and accepts writes by valid/ready; all inputs are synchronous.
//
// What this block does
// - Format 103 sends four link-selected monitor words
// - Format 103 word n at bytes 2n-2, 2n-1
// - Format 103 selectors are link numbers
// - Format 106 accepts four serial-selected write words
// - Format 106 word n low byte first
// - Format 106 write selectors are serial numbers
// - Duplicate write selectors: highest numbered wins
// - Format 107 sends four serial-selected monitor words
// - Format 107 word n at bytes 2n-2, 2n-1
// - Format 107 selectors are serial numbers
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module uda_assembly import uda_pkg::*; #(
    parameter int SEL_W = SEL_WIDTH,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_WIDTH-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Output assembly bytes from the master
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_ready_o,
    // Input assembly bytes to the master
    input wire logic tx_start_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    input wire logic tx_ready_i,
    // Parameter write port
    output logic wr_valid_o,
    output logic [SEL_W-1:0] wr_param_o,
    output logic wr_serial_o,
    output logic [WORD_W-1:0] wr_data_o,
    input wire logic wr_ready_i,
    // Parameter monitor port
    output logic mon_rd_o,
    output logic [SEL_W-1:0] mon_param_o,
    output logic mon_serial_o,
    input wire logic [WORD_W-1:0] mon_data_i
);
    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [FMT_W-1:0] out_fmt, next_out_fmt, in_fmt, next_in_fmt;
    logic [SEL_W-1:0] sel [NUM_SEL];
    logic [SEL_W-1:0] next_sel [NUM_SEL];
    logic [31:0] rd_mux, next_prdata;
    logic err_mux, next_pslverr;
    logic [CNT_W-1:0] applied, next_applied, dropped, next_dropped;
    logic [ADDR_WIDTH-1:0] rel_addr;
    logic [3:0] sel_idx;
    logic in_sel_range;
    logic apb_wr;
    // Input assembly state read by the status decode and slot qualification
    logic tx_serial, next_tx_serial;
    logic tx_busy;

    assign rel_addr = paddr_i - OFS_SEL_BASE;
    assign sel_idx = rel_addr[5:2];
    assign in_sel_range = (paddr_i >= OFS_SEL_BASE) && (paddr_i <= OFS_SEL_LAST)
                          && (paddr_i[1:0] == 2'b00);
    // Zero wait states: answer data is captured in the setup cycle
    assign pready_o = psel_i & penable_i;
    assign apb_wr = psel_i & penable_i & pwrite_i & ~err_mux;

    // Read decode; status is read only, so a write to it is an error
    always_comb begin
        rd_mux = 32'h0000_0000;
        err_mux = 1'b0;
        if (paddr_i == OFS_OUT_FMT) begin
            rd_mux[FMT_W-1:0] = out_fmt;
        end else if (paddr_i == OFS_IN_FMT) begin
            rd_mux[FMT_W-1:0] = in_fmt;
        end else if (in_sel_range) begin
            rd_mux[SEL_W-1:0] = sel[sel_idx];
        end else if (paddr_i == OFS_STATUS) begin
            rd_mux[ST_APPLIED_LSB +: CNT_W] = applied;
            rd_mux[ST_DROPPED_LSB +: CNT_W] = dropped;
            rd_mux[ST_RX_BUSY] = rx_ready_o == 1'b0;
            rd_mux[ST_TX_BUSY] = tx_busy;
            err_mux = pwrite_i;
        end else begin
            err_mux = 1'b1;
        end
    end

    // Next register values
    always_comb begin
        next_out_fmt = out_fmt;
        next_in_fmt = in_fmt;
        next_sel = sel;
        next_prdata = prdata_o;
        next_pslverr = pslverr_o;
        if (psel_i && !penable_i) begin
            next_prdata = pwrite_i ? 32'h0000_0000 : rd_mux;
            next_pslverr = err_mux;
        end
        if (apb_wr) begin
            if (paddr_i == OFS_OUT_FMT) begin
                next_out_fmt = pwdata_i[FMT_W-1:0];
            end else if (paddr_i == OFS_IN_FMT) begin
                next_in_fmt = pwdata_i[FMT_W-1:0];
            end else if (in_sel_range) begin
                next_sel[sel_idx] = pwdata_i[SEL_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_fmt <= FMT_RESET;
            in_fmt <= FMT_RESET;
            for (int i = 0; i < NUM_SEL; i++) begin
                sel[i] <= SEL_RESET;
            end
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            out_fmt <= next_out_fmt;
            in_fmt <= next_in_fmt;
            sel <= next_sel;
            prdata_o <= next_prdata;
            pslverr_o <= next_pslverr;
        end
    end

    // ****************************************************************
    // Slot qualification
    // ****************************************************************
    logic [SLOTS-1:0] wr_ok, mon_ok;

    // True when a higher-numbered write selector names the same parameter
    function automatic logic higher_dup(input int s);
        higher_dup = 1'b0;
        for (int j = s + 1; j < SLOTS; j++) begin
            if (sel[SEL_SER_WR+j] == sel[SEL_SER_WR+s]) begin
                higher_dup = 1'b1;
            end
        end
    endfunction

    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
        assign wr_ok[s] = (sel[SEL_SER_WR+s] != SEL_UNASSIGNED) && !higher_dup(s);
        assign mon_ok[s] = tx_serial ? (sel[SEL_SER_MON+s] != SEL_UNASSIGNED)
                                     : (sel[SEL_LINK_MON+s] != SEL_UNASSIGNED);
    end

    // ****************************************************************
    // Output assembly: collect eight bytes, then write the parameters
    // ****************************************************************
    uda_rx_state_t rx_state, next_rx_state;
    logic [2:0] rx_cnt, next_rx_cnt;
    logic [1:0] wr_slot, next_wr_slot;
    logic [WORD_W-1:0] rx_word [SLOTS];
    logic [WORD_W-1:0] next_rx_word [SLOTS];

    assign rx_ready_o = (rx_state == RX_COLLECT);
    assign wr_valid_o = (rx_state == RX_WRITE) && wr_ok[wr_slot];
    assign wr_param_o = sel[SEL_SER_WR+int'(wr_slot)];
    assign wr_serial_o = 1'b1;
    assign wr_data_o = rx_word[wr_slot];

    // Frames taken under another output format are counted and dropped
    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_wr_slot = wr_slot;
        next_rx_word = rx_word;
        next_applied = applied;
        next_dropped = dropped;
        unique case (rx_state)
            RX_COLLECT: begin
                if (rx_valid_i) begin
                    if (rx_cnt[0]) begin
                        next_rx_word[rx_cnt[2:1]][15:8] = rx_data_i;
                    end else begin
                        next_rx_word[rx_cnt[2:1]][7:0] = rx_data_i;
                    end
                    next_rx_cnt = rx_cnt + 1'b1;
                    if (rx_cnt == LAST_BYTE) begin
                        if (out_fmt == FMT_OUT_SERIAL) begin
                            next_rx_state = RX_WRITE;
                            next_wr_slot = 2'h0;
                        end else begin
                            next_dropped = dropped + 1'b1;
                        end
                    end
                end
            end
            RX_WRITE: begin
                // Unassigned slots are skipped without a write strobe
                if (!wr_ok[wr_slot] || wr_ready_i) begin
                    next_wr_slot = wr_slot + 1'b1;
                    if (wr_slot == LAST_SLOT) begin
                        next_rx_state = RX_COLLECT;
                        next_applied = applied + 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_state <= RX_COLLECT;
            rx_cnt <= 3'h0;
            wr_slot <= 2'h0;
            for (int i = 0; i < SLOTS; i++) begin
                rx_word[i] <= '0;
            end
            applied <= '0;
            dropped <= '0;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            wr_slot <= next_wr_slot;
            rx_word <= next_rx_word;
            applied <= next_applied;
            dropped <= next_dropped;
        end
    end

    // ****************************************************************
    // Input assembly: read four monitor words and stream them out
    // ****************************************************************
    uda_tx_state_t tx_state, next_tx_state;
    logic [1:0] tx_slot, next_tx_slot;
    logic [WORD_W-1:0] tx_word, next_tx_word;
    uda_stream_if #(.W(9)) tx_push ();
    uda_stream_if #(.W(9)) tx_pop ();

    assign tx_busy = (tx_state != TX_IDLE);
    assign mon_rd_o = (tx_state == TX_READ) && mon_ok[tx_slot];
    assign mon_serial_o = tx_serial;
    assign mon_param_o = tx_serial ? sel[SEL_SER_MON+int'(tx_slot)]
                                   : sel[SEL_LINK_MON+int'(tx_slot)];
    assign tx_push.valid = (tx_state == TX_LO) || (tx_state == TX_HI);
    assign tx_push.data = (tx_state == TX_HI)
                        ? {(tx_slot == LAST_SLOT), tx_word[15:8]}
                        : {1'b0, tx_word[7:0]};
    assign tx_valid_o = tx_pop.valid;
    assign tx_data_o = tx_pop.data[7:0];
    assign tx_last_o = tx_pop.data[8];
    assign tx_pop.ready = tx_ready_i;

    // A start under any other input format is ignored
    always_comb begin
        next_tx_state = tx_state;
        next_tx_slot = tx_slot;
        next_tx_serial = tx_serial;
        next_tx_word = tx_word;
        unique case (tx_state)
            TX_IDLE: begin
                if (tx_start_i && (in_fmt == FMT_IN_LINK || in_fmt == FMT_IN_SERIAL)) begin
                    next_tx_state = TX_READ;
                    next_tx_slot = 2'h0;
                    next_tx_serial = (in_fmt == FMT_IN_SERIAL);
                end
            end
            TX_READ: begin
                next_tx_word = mon_ok[tx_slot] ? mon_data_i : '0;
                next_tx_state = TX_LO;
            end
            TX_LO: begin
                if (tx_push.ready) begin
                    next_tx_state = TX_HI;
                end
            end
            TX_HI: begin
                if (tx_push.ready) begin
                    next_tx_slot = tx_slot + 1'b1;
                    next_tx_state = (tx_slot == LAST_SLOT) ? TX_IDLE : TX_READ;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_state <= TX_IDLE;
            tx_slot <= 2'h0;
            tx_serial <= 1'b0;
            tx_word <= '0;
        end else begin
            tx_state <= next_tx_state;
            tx_slot <= next_tx_slot;
            tx_serial <= next_tx_serial;
            tx_word <= next_tx_word;
        end
    end

    // Two-entry buffer so a stalling receiver loses no byte
    uda_buf #(.W(9), .DEPTH(BUF_DEPTH)) u_tx_buf (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .push(tx_push.snk),
        .pop(tx_pop.src)
    );
endmodule // uda_assembly
`default_nettype wire

// [test/uda_checker.sv]
// Port checker for the assembly engine.
// Assumes it is bound onto uda_assembly with one clock and reset.
`timescale 1ns/1ps
`default_nettype none
module uda_checker import uda_pkg::*; #(parameter int SEL_W = SEL_WIDTH) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [ADDR_WIDTH-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Streams
    input wire logic rx_valid_i,
    input wire logic rx_ready_o,
    input wire logic tx_valid_o,
    input wire logic tx_last_o,
    input wire logic tx_ready_i,
    // Parameter ports
    input wire logic wr_valid_o,
    input wire logic [SEL_W-1:0] wr_param_o,
    input wire logic wr_serial_o,
    input wire logic [WORD_W-1:0] wr_data_o,
    input wire logic wr_ready_i,
    input wire logic mon_rd_o,
    input wire logic [SEL_W-1:0] mon_param_o
);
    logic [2:0] rx_cnt;
    logic [2:0] next_rx_cnt;
    logic [2:0] tx_cnt;
    logic [2:0] next_tx_cnt;
    // ************************************************************
    // Byte position counters
    // ************************************************************
    // No framing signal, so byte positions are counted from reset
    always_comb begin
        next_rx_cnt = rx_cnt + {2'h0, rx_valid_i & rx_ready_o};
        next_tx_cnt = tx_cnt + {2'h0, tx_valid_o & tx_ready_i};
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_cnt <= 3'h0;
            tx_cnt <= 3'h0;
        end else begin
            rx_cnt <= next_rx_cnt;
            tx_cnt <= next_tx_cnt;
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr_wait;
        wr_valid_o && !wr_ready_i;
    endsequence
    sequence s_wr_held;
        wr_valid_o && $stable(wr_param_o) && $stable(wr_data_o);
    endsequence
    apb_ready_a: assert property (pready_o == (psel_i && penable_i))
        else $error("pready not tied to access phase");
    bad_addr_a: assert property (psel_i && !penable_i && paddr_i > OFS_STATUS |=> pslverr_o)
        else $error("unmapped access not refused");
    wr_hold_a: assert property (s_wr_wait |=> s_wr_held)
        else $error("write request dropped before accept");
    wr_serial_a: assert property (wr_valid_o |-> wr_serial_o)
        else $error("write not in serial numbering");
    wr_assigned_a: assert property (wr_valid_o |-> wr_param_o != 16'h0000)
        else $error("write to unassigned slot");
    wr_block_a: assert property (wr_valid_o |-> !rx_ready_o)
        else $error("bytes taken during writes");
    frame_end_a: assert property ($fell(rx_ready_o) |-> $past(rx_valid_i && rx_cnt == 3'h7))
        else $error("write phase not after eighth byte");
    mon_assigned_a: assert property (mon_rd_o |-> mon_param_o != 16'h0000)
        else $error("monitor read of unassigned slot");
    tx_last_a: assert property (tx_valid_o && tx_ready_i |-> tx_last_o == (tx_cnt == 3'h7))
        else $error("last flag off eighth byte");
endmodule // uda_checker
bind uda_assembly uda_checker #(.SEL_W(SEL_W)) i_chk (.clock_i, .arst_n_i, .psel_i,
    .penable_i, .paddr_i, .pready_o, .pslverr_o, .rx_valid_i, .rx_ready_o, .tx_valid_o,
    .tx_last_o, .tx_ready_i, .wr_valid_o, .wr_param_o, .wr_serial_o, .wr_data_o,
    .wr_ready_i, .mon_rd_o, .mon_param_o);
`default_nettype wire

// [test/uda_store_model.sv]
// Parameter store model on the far side of the write and monitor ports.
// Assumes the bench asks for slow answers through slow_i.
`timescale 1ns/1ps
`default_nettype none
module uda_store_model import uda_pkg::*; (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Control
    input wire logic slow_i,
    // Ports
    input wire logic mon_rd_i,
    input wire logic [SEL_WIDTH-1:0] mon_param_i,
    input wire logic mon_serial_i,
    output logic [WORD_W-1:0] mon_data_o,
    output logic wr_ready_o
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [WORD_W-1:0] val;
    // Value differs by numbering so a bank mix-up shows
    always_comb begin
        val = mon_param_i ^ (mon_serial_i ? 16'ha5c3 : 16'h3c96);
        mon_data_o = mon_rd_i ? val : ~val; // Inverse outside a read
        next_cnt = cnt + 2'h1;
        wr_ready_o = !slow_i || cnt == 2'h3; // Slow: one accept in four
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 2'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // uda_store_model
`default_nettype wire

// [test/uda_assembly_tb_top.sv]
// Self-checking bench for the assembly engine.
// Assumes the checker is bound and the store model answers monitor reads.
`timescale 1ns/1ps
`default_nettype none
module uda_assembly_tb_top import uda_pkg::*; ;
    logic clock_i = 0;
    logic arst_n_i = 0;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, r;
    logic pready_o, pslverr_o, e, rx_valid_i = 0, rx_ready_o, tx_start_i = 0;
    logic [7:0] rx_data_i = 0, tx_data_o;
    logic tx_valid_o, tx_last_o, tx_ready_i = 0, wr_valid_o, wr_serial_o, wr_ready_i;
    logic [15:0] wr_param_o, wr_data_o, mon_param_o, mon_data_i;
    logic mon_rd_o, mon_serial_o, slow = 0;
    logic [39:0] wrq[$], txq[$];
    int err_total = 0, checks = 0;
    uda_assembly i_dut (.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_valid_i, .rx_data_i, .rx_ready_o,
        .tx_start_i, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .wr_valid_o,
        .wr_param_o, .wr_serial_o, .wr_data_o, .wr_ready_i, .mon_rd_o, .mon_param_o,
        .mon_serial_o, .mon_data_i);
    uda_store_model i_store (.clock_i, .arst_n_i, .slow_i(slow), .mon_rd_i(mon_rd_o),
        .mon_param_i(mon_param_o), .mon_serial_i(mon_serial_o), .mon_data_o(mon_data_i),
        .wr_ready_o(wr_ready_i));
    always #12.5 clock_i = ~clock_i;
    task cmp(input logic [39:0] g, input logic [39:0] x);
        checks++;
        if (g !== x) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clock_i) penable_i <= 1;
        // No wait limit here: only the watchdog ends a stuck transfer
        do @(posedge clock_i); while (pready_o !== 1'b1);
        r = prdata_o; e = pslverr_o;
        psel_i <= 0; penable_i <= 0;
        @(posedge clock_i); // Idle cycle so the next call never re-drives in this step
    endtask
    function logic [15:0] mf(input logic [15:0] p, input logic s);
        return p ^ (s ? 16'ha5c3 : 16'h3c96);
    endfunction
    task settle;
        int n;
        n = 0;
        while ((wrq.size() + txq.size() != 0 || rx_ready_o !== 1'b1) && n++ < 400)
            @(posedge clock_i);
        if (n > 400) err_total++; // Undrained notes or a stuck engine count as a mismatch
        repeat (20) @(posedge clock_i);
    endtask
    // Output frame with random selectors; duplicates and zeros are likely
    task rx_frame(input bit on);
        logic [15:0] s[4];
        logic [63:0] b;
        bit ok;
        int n, m;
        b = {$urandom, $urandom};
        for (n = 0; n < 4; n++) begin
            s[n] = 16'($urandom_range(0, 3));
            apb(1, 12'h020 + 12'(4 * n), {16'h0, s[n]});
        end
        for (n = 0; n < 4; n++) begin
            ok = on && s[n] != 0;
            for (m = n + 1; m < 4; m++) if (s[m] == s[n]) ok = 0;
            if (ok) wrq.push_back({1'b1, s[n], b[16*n+:16]});
        end
        for (n = 0; n < 8; n++) begin
            rx_valid_i <= 1; rx_data_i <= b[8*n+:8];
            do @(posedge clock_i); while (rx_ready_o !== 1'b1);
        end
        rx_valid_i <= 0;
        settle();
    endtask
    // Input frame; both selector banks differ so the wrong bank shows
    task tx_run(input logic [7:0] f);
        logic [15:0] a[4], c[4], w;
        int n;
        apb(1, OFS_IN_FMT, {24'h0, f});
        for (n = 0; n < 4; n++) begin
            a[n] = $urandom_range(0, 2) == 0 ? 16'h0 : 16'($urandom);
            c[n] = $urandom_range(0, 2) == 0 ? 16'h0 : 16'($urandom);
            apb(1, 12'h010 + 12'(4 * n), {16'h0, a[n]});
            apb(1, 12'h030 + 12'(4 * n), {16'h0, c[n]});
            w = f == FMT_IN_SERIAL ? c[n] : a[n];
            w = w == 0 ? 16'h0 : mf(w, f == FMT_IN_SERIAL);
            if (f == FMT_IN_LINK || f == FMT_IN_SERIAL) begin
                txq.push_back({32'h0, w[7:0]});
                txq.push_back({31'h0, n == 3, w[15:8]});
            end
        end
        apb(0, 12'h010, 0);
        cmp(r, {16'h0, a[0]});
        tx_start_i <= 1;
        @(posedge clock_i) tx_start_i <= 0;
        settle();
    endtask
    // Result watchers take the oldest note per handshake
    always @(posedge clock_i) begin
        if (arst_n_i && wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
            cmp({wr_serial_o, wr_param_o, wr_data_o}, wrq.size() ? wrq.pop_front() : 'x);
        if (arst_n_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
            cmp({tx_last_o, tx_data_o}, txq.size() ? txq.pop_front() : 'x);
        tx_ready_i <= $urandom_range(0, 3) != 0;
        slow <= $urandom_range(0, 1);
    end
    initial begin
        #1000000;
        err_total++;
        final_report();
    end
    initial begin
        int k;
        void'($urandom(32'h1caab449));
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1;
        @(posedge clock_i);
        apb(0, OFS_OUT_FMT, 0);
        cmp({e, r}, 0);
        apb(0, 12'h100, 0);
        cmp({e, r}, {1'b1, 32'h0});
        apb(1, OFS_STATUS, 1);
        cmp(e, 1);
        apb(1, OFS_OUT_FMT, FMT_OUT_SERIAL);
        for (k = 0; k < 4; k++) rx_frame(1);
        apb(1, OFS_OUT_FMT, 0);
        rx_frame(0);
        tx_run(FMT_IN_LINK);
        tx_run(FMT_IN_SERIAL);
        tx_run(8'h00);
        apb(0, OFS_STATUS, 0);
        cmp({e, r}, 32'h0000_0104);
        final_report();
    end
endmodule // uda_assembly_tb_top
`default_nettype wire
